// [vdc_ctrl_regs.sv]
// Contract
// - Y clamp level is fixed 60 when override set, else programmed.
// - AGC sync reference is fixed 38h when override set, else field.
// - Upper nibble is sync miss threshold, lower is detect window.
// - Clamp position is an 8-bit offset from the PLL sync edge.
// - Clamp pulse start and end in units of 8 clocks after position.
// - Vertical lock times, window mode, auto field and integration.
// - Vertical sync output delay in half-line steps, 5 bits.
// - Color killer threshold and hysteresis fields with reset values.
// - Luma fine delay is two's complement, minus four to plus three.
// - Gating bit suppresses horizontal sync during video loss.
// - Horizontal PLL acquisition speed from a 2-bit field.
// - Burst PLL speed, ACC time constant and chroma bandwidth fields.
// - Separate noisy killer enables for NTSC, PAL, SECAM, reset 1.
// - Forced or loss-substituted output color, blue or black.
// - Read-only copy protection flags; type valid only with stripe.
// - Read-only signal status indicators.
// - Free-run rate: 0X automatic, 10 is 60 Hz, 11 is 50 Hz.
// - Clamp mode and slice level fields, both reset to 1.
// - Sensitivity registers written indirectly through a 2-bit index.
// - Index 0 NTSC, 1 SECAM, 2 PAL, 3 weak threshold, own resets.
// - Per-channel clamp disable bits for Y, C and V.
// - ADC source select, filter bypass per channel, analog mix.
//
// Purpose: APB control and status register bank of the video decoder.
// Assumes: sync_edge and hsync_in come from logic on mclk; status and
//          video loss inputs are asynchronous.
// Notes:   Zero wait state slave; read data registered in setup phase.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "vdc_consts.svh"

module vdc_ctrl_regs #(
    parameter int APB_AW = 12
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic                   pslverr,
    output logic [31:0]            prdata,
    input  wire logic [7:0]        copy_protect_in,
    input  wire logic [7:0]        signal_status_in,
    input  wire logic [7:0]        horizontal_monitor_in,
    input  wire logic              video_loss_in,
    input  wire logic              sync_edge,
    input  wire logic              hsync_in,
    output logic                   hsync_out,
    output logic                   clamp_pulse,
    output logic [6:0]             y_clamp_level_value,
    output logic [6:0]             sync_ref_amplitude,
    output logic [3:0]             sync_miss_threshold,
    output logic [3:0]             hsync_detect_window,
    output logic [1:0]             vertical_lock_in_time,
    output logic [1:0]             vertical_lock_out_time,
    output logic                   vertical_window_mode,
    output logic                   auto_field_generation,
    output logic                   vertical_integration_time,
    output logic [4:0]             vsync_output_delay,
    output logic [1:0]             killer_hysteresis,
    output logic [5:0]             killer_threshold,
    output logic signed [2:0]      luma_fine_delay,
    output vdc_pkg::vdc_hpll_e     hpll_acquisition_speed,
    output vdc_pkg::vdc_acc_e      acc_time_constant,
    output logic [1:0]             burst_pll_speed,
    output logic [1:0]             chroma_lpf_bandwidth,
    output logic                   noisy_killer_ntsc,
    output logic                   noisy_killer_pal,
    output logic                   noisy_killer_secam,
    output logic                   force_color_active,
    output logic                   force_color_blue,
    output logic                   free_run_auto,
    output logic                   free_run_50hz,
    output logic [1:0]             clamp_mode_select,
    output logic [1:0]             slice_level,
    output logic [5:0]             ntsc_id_sensitivity,
    output logic [5:0]             secam_id_sensitivity,
    output logic [5:0]             pal_id_sensitivity,
    output logic [5:0]             weak_signal_threshold,
    output logic                   y_clamp_disable,
    output logic                   c_clamp_disable,
    output logic                   v_clamp_disable,
    output logic                   adc_source_select,
    output logic                   aaf_bypass_y,
    output logic                   aaf_bypass_v,
    output logic                   aaf_bypass_c,
    output logic                   analog_yc_mix,
    output logic                   id_detect_sensitivity_bit,
    output logic                   timebase_corrector_enable,
    output logic                   standard_detect_enable
);
    import vdc_pkg::*;

    // Slot lookup: bit 4 marks a plain read/write register
    function automatic logic [4:0] slot_of(input logic [5:0] idx);
        case (idx)
            `VDC_IDX_CLAMP_TIME: slot_of = {1'b1, `VDC_S_CLAMP_TIME};
            `VDC_IDX_YCLAMP:     slot_of = {1'b1, `VDC_S_YCLAMP};
            `VDC_IDX_SYNC_REF:   slot_of = {1'b1, `VDC_S_SYNC_REF};
            `VDC_IDX_MISS_WIN:   slot_of = {1'b1, `VDC_S_MISS_WIN};
            `VDC_IDX_CLAMP_POS:  slot_of = {1'b1, `VDC_S_CLAMP_POS};
            `VDC_IDX_VCTL_ONE:   slot_of = {1'b1, `VDC_S_VCTL_ONE};
            `VDC_IDX_VCTL_TWO:   slot_of = {1'b1, `VDC_S_VCTL_TWO};
            `VDC_IDX_KILLER:     slot_of = {1'b1, `VDC_S_KILLER};
            `VDC_IDX_COMB:       slot_of = {1'b1, `VDC_S_COMB};
            `VDC_IDX_LUMA_DLY:   slot_of = {1'b1, `VDC_S_LUMA_DLY};
            `VDC_IDX_MISC_ONE:   slot_of = {1'b1, `VDC_S_MISC_ONE};
            `VDC_IDX_MISC_TWO:   slot_of = {1'b1, `VDC_S_MISC_TWO};
            `VDC_IDX_MISC_THREE: slot_of = {1'b1, `VDC_S_MISC_THREE};
            `VDC_IDX_CLAMP_MODE: slot_of = {1'b1, `VDC_S_CLAMP_MODE};
            `VDC_IDX_CLAMP_CHAN: slot_of = {1'b1, `VDC_S_CLAMP_CHAN};
            `VDC_IDX_ADC_SEL:    slot_of = {1'b1, `VDC_S_ADC_SEL};
            default:             slot_of = 5'h00;
        endcase
    endfunction

    localparam vdc_byte_t rst_tab [0:`VDC_NSLOT-1] = '{
        `VDC_RST_CLAMP_TIME, `VDC_RST_YCLAMP, `VDC_RST_SYNC_REF,
        `VDC_RST_MISS_WIN, `VDC_RST_CLAMP_POS, `VDC_RST_VCTL_ONE,
        `VDC_RST_VCTL_TWO, `VDC_RST_KILLER, `VDC_RST_COMB,
        `VDC_RST_LUMA_DLY, `VDC_RST_MISC_ONE, `VDC_RST_MISC_TWO,
        `VDC_RST_MISC_THREE, `VDC_RST_CLAMP_MODE, `VDC_RST_CLAMP_CHAN,
        `VDC_RST_ADC_SEL};

    vdc_byte_t   rf [0:`VDC_NSLOT-1];
    logic [5:0]  sens [0:3];
    logic [1:0]  sens_idx;
    logic [7:0]  cp_meta;
    logic [7:0]  cp_sync;
    logic [7:0]  st_meta;
    logic [7:0]  st_sync;
    logic [7:0]  hm_meta;
    logic [7:0]  hm_sync;
    logic        loss_meta;
    logic        loss_sync;
    logic [11:0] clamp_cnt;

    // Bus decode
    wire        aligned   = (paddr[1:0] == 2'b00) &&
                            (paddr[APB_AW-1:8] == '0);
    wire [5:0]  reg_idx   = paddr[7:2];
    wire [4:0]  slot_hit  = slot_of(reg_idx);
    wire        is_plain  = aligned && slot_hit[4];
    wire        is_sens   = aligned && (reg_idx == `VDC_IDX_ID_SENS);
    wire        is_ro     = aligned && ((reg_idx == `VDC_IDX_COPY_STAT) ||
                            (reg_idx == `VDC_IDX_SIG_STAT) ||
                            (reg_idx == `VDC_IDX_HMON));
    wire        mapped    = is_plain || is_sens || is_ro;
    wire        access    = psel && penable;
    wire        bad       = !mapped || (pwrite && is_ro);
    wire        wr_ok     = access && pwrite && !bad && pstrb[0];
    wire        setup_rd  = psel && !penable && !pwrite;
    wire        sens_sel  = (pwdata[5:0] == 6'h00);

    assign pready  = 1'b1;
    assign pslverr = access && bad;

    wire [7:0] cp_view = {cp_sync[7:1], cp_sync[0] & cp_sync[1]};

    wire [7:0] rd_byte =
        is_plain ? rf[slot_hit[3:0]] :
        is_sens  ? {sens_idx, sens[sens_idx]} :
        (reg_idx == `VDC_IDX_COPY_STAT) ? cp_view :
        (reg_idx == `VDC_IDX_SIG_STAT)  ? st_sync :
        (reg_idx == `VDC_IDX_HMON)      ? hm_sync : 8'h00;

    generate
        for (genvar s = 0; s < `VDC_NSLOT; s++) begin : g_rf
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    rf[s] <= rst_tab[s];
                end else if (wr_ok && is_plain &&
                             slot_hit[3:0] == 4'(s)) begin
                    rf[s] <= pwdata[7:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sens_idx <= 2'h0;
        end else if (wr_ok && is_sens && sens_sel) begin
            sens_idx <= pwdata[7:6];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sens[0] <= `VDC_RST_SENS_NTSC;
            sens[1] <= `VDC_RST_SENS_SECAM;
            sens[2] <= `VDC_RST_SENS_PAL;
            sens[3] <= `VDC_RST_SENS_WEAK;
        end else if (wr_ok && is_sens && !sens_sel) begin
            sens[sens_idx] <= pwdata[5:0];
        end
    end

    // Read data captured at setup so it is stable through access
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

    // Status pins are asynchronous: two flops before use
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            {cp_meta, st_meta, hm_meta, loss_meta} <= '0;
            {cp_sync, st_sync, hm_sync, loss_sync} <= '0;
        end else begin
            {cp_meta, st_meta, hm_meta, loss_meta} <= {copy_protect_in,
                signal_status_in, horizontal_monitor_in, video_loss_in};
            {cp_sync, st_sync, hm_sync, loss_sync} <=
                {cp_meta, st_meta, hm_meta, loss_meta};
        end
    end

    // Clamp timing, counted in clocks from the recovered sync edge
    wire [7:0]  pos_off   = rf[`VDC_S_CLAMP_POS];
    wire [3:0]  pulse_beg = rf[`VDC_S_CLAMP_TIME][3:0];
    wire [3:0]  pulse_end = rf[`VDC_S_CLAMP_TIME][7:4];
    wire [11:0] beg_at    = 12'(pos_off) +
                            12'(pulse_beg) * `VDC_CLAMP_UNIT_CLK;
    wire [11:0] end_at    = 12'(pos_off) +
                            12'(pulse_end) * `VDC_CLAMP_UNIT_CLK;
    wire        in_pulse  = (clamp_cnt >= beg_at) && (clamp_cnt < end_at);

    // Counter saturates so a lost sync cannot retrigger the pulse
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            clamp_cnt <= `VDC_CLAMP_CNT_MAX;
        end else if (sync_edge) begin
            clamp_cnt <= 12'h000;
        end else if (clamp_cnt != `VDC_CLAMP_CNT_MAX) begin
            clamp_cnt <= clamp_cnt + 12'h001;
        end
    end

    wire next_hsync = hsync_in && !(rf[`VDC_S_MISC_ONE][1] && loss_sync);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hsync_out   <= 1'b0;
            clamp_pulse <= 1'b0;
        end else begin
            hsync_out   <= next_hsync;
            clamp_pulse <= in_pulse;
        end
    end

    assign y_clamp_level_value = rf[`VDC_S_YCLAMP][7] ?
        `VDC_FIXED_CLAMP_LVL : rf[`VDC_S_YCLAMP][6:0];
    assign sync_ref_amplitude = rf[`VDC_S_SYNC_REF][7] ?
        `VDC_FIXED_SYNC_REF : rf[`VDC_S_SYNC_REF][6:0];
    assign sync_miss_threshold = rf[`VDC_S_MISS_WIN][7:4];
    assign hsync_detect_window = rf[`VDC_S_MISS_WIN][3:0];
    assign vertical_lock_in_time     = rf[`VDC_S_VCTL_ONE][7:6];
    assign vertical_lock_out_time    = rf[`VDC_S_VCTL_ONE][5:4];
    assign vertical_window_mode      = rf[`VDC_S_VCTL_ONE][3];
    assign auto_field_generation     = rf[`VDC_S_VCTL_ONE][1];
    assign vertical_integration_time = rf[`VDC_S_VCTL_ONE][0];
    assign vsync_output_delay = rf[`VDC_S_VCTL_TWO][4:0];
    assign killer_hysteresis = rf[`VDC_S_KILLER][7:6];
    assign killer_threshold  = rf[`VDC_S_KILLER][5:0];
    assign luma_fine_delay = $signed(rf[`VDC_S_LUMA_DLY][6:4]);
    assign hpll_acquisition_speed = vdc_hpll_e'(rf[`VDC_S_MISC_TWO][7:6]);
    assign acc_time_constant    = vdc_acc_e'(rf[`VDC_S_MISC_TWO][5:4]);
    assign burst_pll_speed      = rf[`VDC_S_MISC_TWO][3:2];
    assign chroma_lpf_bandwidth = rf[`VDC_S_MISC_TWO][1:0];
    assign noisy_killer_ntsc  = rf[`VDC_S_MISC_THREE][7];
    assign noisy_killer_pal   = rf[`VDC_S_MISC_THREE][6];
    assign noisy_killer_secam = rf[`VDC_S_MISC_THREE][5];
    assign force_color_active = rf[`VDC_S_MISC_THREE][3] ||
                                (rf[`VDC_S_MISC_THREE][2] && loss_sync);
    assign force_color_blue   = rf[`VDC_S_MISC_THREE][1];
    assign free_run_auto = !rf[`VDC_S_CLAMP_MODE][7];
    assign free_run_50hz = rf[`VDC_S_CLAMP_MODE][7] &&
                           rf[`VDC_S_CLAMP_MODE][6];
    assign clamp_mode_select = rf[`VDC_S_CLAMP_MODE][3:2];
    assign slice_level       = rf[`VDC_S_CLAMP_MODE][1:0];
    assign ntsc_id_sensitivity   = sens[0];
    assign secam_id_sensitivity  = sens[1];
    assign pal_id_sensitivity    = sens[2];
    assign weak_signal_threshold = sens[3];
    assign y_clamp_disable = rf[`VDC_S_CLAMP_CHAN][6];
    assign c_clamp_disable = rf[`VDC_S_CLAMP_CHAN][5];
    assign v_clamp_disable = rf[`VDC_S_CLAMP_CHAN][4];
    assign adc_source_select = rf[`VDC_S_ADC_SEL][7];
    assign aaf_bypass_y      = rf[`VDC_S_ADC_SEL][3];
    assign aaf_bypass_v      = rf[`VDC_S_ADC_SEL][2];
    assign aaf_bypass_c      = rf[`VDC_S_ADC_SEL][1];
    assign analog_yc_mix     = rf[`VDC_S_ADC_SEL][0];
    assign id_detect_sensitivity_bit = rf[`VDC_S_MISC_ONE][4];
    assign timebase_corrector_enable = rf[`VDC_S_MISC_ONE][3];
    assign standard_detect_enable    = rf[`VDC_S_MISC_ONE][2];
endmodule

// [vdc_consts.svh]
// Purpose: Register indexes, reset values and fixed levels of the
//          video decoder control bank.
// Assumes: Byte address of a register is four times its index.
// Notes:   Definitions only.
`ifndef VDC_CONSTS_SVH
`define VDC_CONSTS_SVH

// Register indexes
`define VDC_IDX_CLAMP_TIME   6'h20
`define VDC_IDX_YCLAMP       6'h24
`define VDC_IDX_SYNC_REF     6'h25
`define VDC_IDX_MISS_WIN     6'h26
`define VDC_IDX_CLAMP_POS    6'h27
`define VDC_IDX_VCTL_ONE     6'h28
`define VDC_IDX_VCTL_TWO     6'h29
`define VDC_IDX_KILLER       6'h2A
`define VDC_IDX_COMB         6'h2B
`define VDC_IDX_LUMA_DLY     6'h2C
`define VDC_IDX_MISC_ONE     6'h2D
`define VDC_IDX_MISC_TWO     6'h2E
`define VDC_IDX_MISC_THREE   6'h2F
`define VDC_IDX_COPY_STAT    6'h30
`define VDC_IDX_SIG_STAT     6'h31
`define VDC_IDX_HMON         6'h32
`define VDC_IDX_CLAMP_MODE   6'h33
`define VDC_IDX_ID_SENS      6'h34
`define VDC_IDX_CLAMP_CHAN   6'h35
`define VDC_IDX_ADC_SEL      6'h38

// Storage slots of the plain read/write registers
`define VDC_NSLOT            16
`define VDC_S_CLAMP_TIME     4'h0
`define VDC_S_YCLAMP         4'h1
`define VDC_S_SYNC_REF       4'h2
`define VDC_S_MISS_WIN       4'h3
`define VDC_S_CLAMP_POS      4'h4
`define VDC_S_VCTL_ONE       4'h5
`define VDC_S_VCTL_TWO       4'h6
`define VDC_S_KILLER         4'h7
`define VDC_S_COMB           4'h8
`define VDC_S_LUMA_DLY       4'h9
`define VDC_S_MISC_ONE       4'hA
`define VDC_S_MISC_TWO       4'hB
`define VDC_S_MISC_THREE     4'hC
`define VDC_S_CLAMP_MODE     4'hD
`define VDC_S_CLAMP_CHAN     4'hE
`define VDC_S_ADC_SEL        4'hF

// Reset values
`define VDC_RST_CLAMP_TIME   8'h50
`define VDC_RST_YCLAMP       8'hBC
`define VDC_RST_SYNC_REF     8'hB8
`define VDC_RST_MISS_WIN     8'h44
`define VDC_RST_CLAMP_POS    8'h2A
`define VDC_RST_VCTL_ONE     8'h00
`define VDC_RST_VCTL_TWO     8'h00
`define VDC_RST_KILLER       8'h78
`define VDC_RST_COMB         8'h44
`define VDC_RST_LUMA_DLY     8'h30
`define VDC_RST_MISC_ONE     8'h14
`define VDC_RST_MISC_TWO     8'h65
`define VDC_RST_MISC_THREE   8'hE0
`define VDC_RST_CLAMP_MODE   8'h05
`define VDC_RST_CLAMP_CHAN   8'h00
`define VDC_RST_ADC_SEL      8'h80
`define VDC_RST_SENS_NTSC    6'h1E
`define VDC_RST_SENS_SECAM   6'h20
`define VDC_RST_SENS_PAL     6'h1C
`define VDC_RST_SENS_WEAK    6'h2A

// Fixed levels and clamp timing unit
`define VDC_FIXED_CLAMP_LVL  7'h3C
`define VDC_FIXED_SYNC_REF   7'h38
`define VDC_CLAMP_UNIT_CLK   12'h008
`define VDC_CLAMP_CNT_MAX    12'hFFF

`endif

// [vdc_pkg.sv]
// Purpose: Types shared by the video decoder control bank.
// Assumes: Constants live in vdc_consts.svh.
// Notes:   Encodings follow the field codes of the registers.
package vdc_pkg;
    typedef enum logic [1:0] {
        VDC_HPLL_SLOW, VDC_HPLL_MEDIUM, VDC_HPLL_AUTO, VDC_HPLL_FAST
    } vdc_hpll_e;
    typedef enum logic [1:0] {
        VDC_ACC_OFF, VDC_ACC_SLOW, VDC_ACC_MEDIUM, VDC_ACC_FAST
    } vdc_acc_e;
    typedef logic [7:0] vdc_byte_t;
endpackage

// [vdc_ctrl_regs_assertions.sv]
// Purpose: Port checks for the video decoder control bank.
// Assumes: Register writes land at the APB access edge.
// Notes:   Bound to every instance of the bank.
`timescale 1ns/1ps
`include "vdc_consts.svh"
module vdc_ctrl_regs_chk #(
    parameter int APB_AW = 12
) (
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic              pslverr,
    input wire logic              video_loss_in,
    input wire logic              hsync_in,
    input wire logic              hsync_out,
    input wire logic              force_color_active,
    input wire logic [6:0]        y_clamp_level_value,
    input wire logic [6:0]        sync_ref_amplitude,
    input wire logic [3:0]        sync_miss_threshold,
    input wire logic [3:0]        hsync_detect_window,
    input wire logic [5:0]        ntsc_id_sensitivity,
    input wire logic [5:0]        pal_id_sensitivity
);
    logic [7:0] wd;
    wire        acc = psel && penable && paddr[APB_AW-1:8] == '0;
    wire  [5:0] idx = paddr[7:2];
    wire        wr  = acc && pwrite && pstrb[0] && paddr[1:0] == 2'b00;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Write byte, seen one cycle later
    always_ff @(posedge mclk) begin
        wd <= pwdata[7:0];
    end
    clamp_level_a: assert property (
        wr && idx == `VDC_IDX_YCLAMP |=> y_clamp_level_value ==
        (wd[7] ? 7'h3C : wd[6:0])) else $error("y clamp level wrong");
    sync_ref_a: assert property (
        wr && idx == `VDC_IDX_SYNC_REF |=> sync_ref_amplitude ==
        (wd[7] ? 7'h38 : wd[6:0])) else $error("sync reference wrong");
    miss_split_a: assert property (
        wr && idx == `VDC_IDX_MISS_WIN |=> {sync_miss_threshold,
        hsync_detect_window} == wd) else $error("miss split wrong");
    ro_write_a: assert property (
        acc && pwrite && idx == `VDC_IDX_COPY_STAT |-> pslverr)
        else $error("read-only write taken");
    hsync_follow_a: assert property (
        hsync_out |-> $past(hsync_in)) else $error("hsync out unprompted");
    hsync_free_a: assert property (
        (!video_loss_in) [*4] |=> hsync_out == $past(hsync_in))
        else $error("hsync dropped");
    force_on_a: assert property (
        wr && idx == `VDC_IDX_MISC_THREE && pwdata[3] |=> force_color_active)
        else $error("force not active");
    index_write_a: assert property (
        wr && idx == `VDC_IDX_ID_SENS && pwdata[5:0] == 6'h00 |=>
        $stable(ntsc_id_sensitivity) && $stable(pal_id_sensitivity))
        else $error("index write stored");
endmodule

bind vdc_ctrl_regs vdc_ctrl_regs_chk #(.APB_AW(APB_AW)) u_chk (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pslverr(pslverr), .video_loss_in(video_loss_in),
    .hsync_in(hsync_in), .hsync_out(hsync_out),
    .force_color_active(force_color_active),
    .y_clamp_level_value(y_clamp_level_value),
    .sync_ref_amplitude(sync_ref_amplitude),
    .sync_miss_threshold(sync_miss_threshold),
    .hsync_detect_window(hsync_detect_window),
    .ntsc_id_sensitivity(ntsc_id_sensitivity),
    .pal_id_sensitivity(pal_id_sensitivity)
);

// [tb.sv]
// Purpose: Self-checking bench of the video decoder control bank.
// Assumes: Zero wait state APB slave, byte address four times index.
// Notes:   Status pins need three edges to reach a read.
`timescale 1ns/1ps
`include "vdc_consts.svh"
module tb;
    import vdc_pkg::*;
    logic        mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        video_loss_in = 0, sync_edge = 0, hsync_in = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [3:0]  pstrb = 4'hF;
    logic [7:0]  copy_protect_in = 0, signal_status_in = 8'h5A, rd;
    logic        pready, pslverr, hsync_out, clamp_pulse, er;
    logic        force_color_active, force_color_blue;
    logic        free_run_auto, free_run_50hz;
    logic [6:0]  y_clamp_level_value, sync_ref_amplitude;
    logic [3:0]  sync_miss_threshold, hsync_detect_window;
    logic [2:0]  luma_fine_delay;
    vdc_hpll_e   hpll_acquisition_speed;
    vdc_acc_e    acc_time_constant;
    logic [1:0]  burst_pll_speed, chroma_lpf_bandwidth;
    logic [5:0]  ntsc_id_sensitivity, secam_id_sensitivity;
    logic [5:0]  pal_id_sensitivity, weak_signal_threshold;
    int          n_fail = 0, comparisons = 0;
    logic [5:0]  ri [17] = '{6'h20, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28,
        6'h29, 6'h2A, 6'h2B, 6'h2C, 6'h2D, 6'h2E, 6'h2F, 6'h33, 6'h34,
        6'h35, 6'h38};
    logic [7:0]  rv [17] = '{8'h50, 8'hBC, 8'hB8, 8'h44, 8'h2A, 8'h00,
        8'h00, 8'h78, 8'h44, 8'h30, 8'h14, 8'h65, 8'hE0, 8'h05, 8'h1E,
        8'h00, 8'h80};
    always #4 mclk = ~mclk;
    vdc_ctrl_regs #(.APB_AW(12)) uut (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .copy_protect_in(copy_protect_in), .video_loss_in(video_loss_in),
        .signal_status_in(signal_status_in), .horizontal_monitor_in(8'h3C),
        .sync_edge(sync_edge), .hsync_in(hsync_in), .hsync_out(hsync_out),
        .clamp_pulse(clamp_pulse), .y_clamp_level_value(y_clamp_level_value),
        .sync_ref_amplitude(sync_ref_amplitude),
        .sync_miss_threshold(sync_miss_threshold),
        .hsync_detect_window(hsync_detect_window),
        .vertical_lock_in_time(), .vertical_lock_out_time(),
        .vertical_window_mode(), .auto_field_generation(),
        .vertical_integration_time(), .vsync_output_delay(),
        .killer_hysteresis(), .killer_threshold(),
        .luma_fine_delay(luma_fine_delay),
        .hpll_acquisition_speed(hpll_acquisition_speed),
        .acc_time_constant(acc_time_constant),
        .burst_pll_speed(burst_pll_speed),
        .chroma_lpf_bandwidth(chroma_lpf_bandwidth),
        .noisy_killer_ntsc(), .noisy_killer_pal(), .noisy_killer_secam(),
        .force_color_active(force_color_active),
        .force_color_blue(force_color_blue), .free_run_auto(free_run_auto),
        .free_run_50hz(free_run_50hz), .clamp_mode_select(), .slice_level(),
        .ntsc_id_sensitivity(ntsc_id_sensitivity),
        .secam_id_sensitivity(secam_id_sensitivity),
        .pal_id_sensitivity(pal_id_sensitivity),
        .weak_signal_threshold(weak_signal_threshold),
        .y_clamp_disable(), .c_clamp_disable(), .v_clamp_disable(),
        .adc_source_select(), .aaf_bypass_y(), .aaf_bypass_v(),
        .aaf_bypass_c(), .analog_yc_mix(), .id_detect_sensitivity_bit(),
        .timebase_corrector_enable(), .standard_detect_enable()
    );
    task automatic end_of_test;
        if (n_fail == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One transfer; returns at a falling edge, outputs settled
    task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d);
        int k;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {4'h0, i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge mclk);
        if (k == 20) begin
            n_fail++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        apb(1'b1, i, d);
    endtask
    task automatic rdc(input logic [5:0] i, input logic [7:0] exp);
        apb(1'b0, i, 8'h00);
        chk(er, 1'b0);
        chk(rd, exp);
    endtask
    task automatic t_reset;
        for (int i = 0; i < 17; i++) rdc(ri[i], rv[i]);
        chk(secam_id_sensitivity, 6'h20);
        chk(weak_signal_threshold, 6'h2A);
    endtask
    task automatic t_fields;
        wr(`VDC_IDX_YCLAMP, 8'h11);
        chk(y_clamp_level_value, 7'h11);
        wr(`VDC_IDX_SYNC_REF, 8'h25);
        chk(sync_ref_amplitude, 7'h25);
        wr(`VDC_IDX_SYNC_REF, 8'hA5);
        chk(sync_ref_amplitude, 7'h38);
        wr(`VDC_IDX_MISS_WIN, 8'h9A);
        chk({sync_miss_threshold, hsync_detect_window}, 8'h9A);
        wr(`VDC_IDX_LUMA_DLY, 8'h40);
        chk(luma_fine_delay, 3'h4);
        for (int k = 0; k < 4; k++) begin
            wr(`VDC_IDX_MISC_TWO, {4{k[1:0]}});
            chk(hpll_acquisition_speed, k);
            chk({acc_time_constant, burst_pll_speed}, {2{k[1:0]}});
            chk(chroma_lpf_bandwidth, k);
            wr(`VDC_IDX_CLAMP_MODE, {k[1:0], 6'h05});
            chk({free_run_auto, free_run_50hz}, {!k[1], k[1] & k[0]});
        end
    endtask
    task automatic t_sens;
        wr(`VDC_IDX_ID_SENS, 8'h80);
        rdc(`VDC_IDX_ID_SENS, 8'h9C);
        wr(`VDC_IDX_ID_SENS, 8'h15);
        wr(`VDC_IDX_ID_SENS, 8'h16);
        chk(pal_id_sensitivity, 6'h16);
        wr(`VDC_IDX_ID_SENS, 8'hC0);
        wr(`VDC_IDX_ID_SENS, 8'h07);
        rdc(`VDC_IDX_ID_SENS, 8'hC7);
        chk(ntsc_id_sensitivity, 6'h1E);
    endtask
    task automatic t_status;
        @(posedge mclk);
        copy_protect_in <= 8'h06;
        repeat (3) @(posedge mclk);
        rdc(`VDC_IDX_COPY_STAT, 8'h06);
        rdc(`VDC_IDX_SIG_STAT, 8'h5A);
        apb(1'b1, `VDC_IDX_COPY_STAT, 8'h00);
        chk(er, 1'b1);
        @(posedge mclk);
        copy_protect_in <= 8'h01;
        repeat (3) @(posedge mclk);
        rdc(`VDC_IDX_COPY_STAT, 8'h00);
        apb(1'b0, 6'h3F, 8'h00);
        chk(er, 1'b1);
    endtask
    task automatic t_loss;
        @(posedge mclk);
        hsync_in <= 1'b1;
        video_loss_in <= 1'b1;
        wr(`VDC_IDX_MISC_ONE, 8'h16);
        wr(`VDC_IDX_MISC_THREE, 8'hE4);
        chk({hsync_out, force_color_active, force_color_blue}, 3'b010);
        wr(`VDC_IDX_MISC_ONE, 8'h14);
        wr(`VDC_IDX_MISC_THREE, 8'hE6);
        chk({hsync_out, force_color_active, force_color_blue}, 3'b111);
        @(posedge mclk);
        video_loss_in <= 1'b0;
        repeat (4) @(posedge mclk);
        wr(`VDC_IDX_MISC_THREE, 8'hE0);
        chk(force_color_active, 1'b0);
        wr(`VDC_IDX_MISC_THREE, 8'hE8);
        chk({force_color_active, force_color_blue}, 2'b10);
    endtask
    task automatic t_clamp;
        int n = 0;
        wr(`VDC_IDX_CLAMP_POS, 8'h04);
        wr(`VDC_IDX_CLAMP_TIME, 8'h21);
        @(posedge mclk);
        sync_edge <= 1'b1;
        @(posedge mclk);
        sync_edge <= 1'b0;
        repeat (60) begin
            @(negedge mclk);
            if (clamp_pulse === 1'b1) n++;
        end
        chk(n, 8);
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_fields();
        t_sens();
        t_status();
        t_loss();
        t_clamp();
        end_of_test();
    end
endmodule
